// file: hw/link_pkg.sv
// Purpose: shared constants, types and helpers of the MII/GMII/RGMII link
// Assumes: one system clock of 250 MHz on both ends
// Notes:   link clocks are made by dividing the system clock
package link_pkg;
  // ****************************************
  // modes and kinds
  // ****************************************
  typedef enum logic [1:0] {SPEED_10 = 2'h0, SPEED_100 = 2'h1, SPEED_1000 = 2'h2} speed_type;
  typedef enum logic [2:0] {MODE_MII = 3'h1, MODE_GMII = 3'h2, MODE_RGMII = 3'h4} mode_type;
  typedef enum logic [2:0] {KIND_DATA = 3'h1, KIND_INVALID = 3'h2, KIND_HALT = 3'h4} kind_type;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_KHZ        = 250000;
  localparam int RATE_10_KHZ    = 2500;
  localparam int RATE_100_KHZ   = 25000;
  localparam int RATE_1000_KHZ  = 125000;
  localparam int DIV_W          = 8;
  // half a link clock period in system cycles
  localparam logic [DIV_W-1:0] HALF_10   = DIV_W'(CLK_KHZ / (2 * RATE_10_KHZ));
  localparam logic [DIV_W-1:0] HALF_100  = DIV_W'(CLK_KHZ / (2 * RATE_100_KHZ));
  localparam logic [DIV_W-1:0] HALF_1000 = DIV_W'(CLK_KHZ / (2 * RATE_1000_KHZ));

  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;
  localparam logic [DIV_W-1:0] DIV_RESET    = 8'h00;
  localparam logic [7:0]       BYTE_RESET   = 8'h00;
  localparam logic [3:0]       NIBBLE_RESET = 4'h0;

  // mii at 10/100, gmii at 1000, unless rgmii is chosen
  function automatic mode_type pick_mode(input speed_type speed, input logic rgmii);
    if (rgmii)
      return MODE_RGMII;
    if (speed == SPEED_1000)
      return MODE_GMII;
    return MODE_MII;
  endfunction : pick_mode

  function automatic logic [DIV_W-1:0] half_count(input speed_type speed);
    case (speed)
      SPEED_10:  return HALF_10;
      SPEED_100: return HALF_100;
      default:   return HALF_1000;
    endcase
  endfunction : half_count
endpackage : link_pkg

// file: hw/link_if.sv
// Purpose: the pins between the mac end and the phy end
// Assumes: every signal is a plain one-way wire
// Notes:   tx_en carries rgmii_tx_control, rx_dv carries rgmii_rx_clock and
//          rx_er carries rgmii_rx_control when rgmii is chosen
`timescale 1ns/1ps
interface link_if;
  logic [7:0] txd;
  logic       tx_en;
  logic       tx_er;
  logic       gtx_clk;
  logic       tx_clk;
  logic       rx_clk;
  logic [7:0] rxd;
  logic       rx_dv;
  logic       rx_er;

  modport phy (
    input  txd,
    input  tx_en,
    input  tx_er,
    input  gtx_clk,
    output tx_clk,
    output rx_clk,
    output rxd,
    output rx_dv,
    output rx_er
  );

  modport mac (
    output txd,
    output tx_en,
    output tx_er,
    output gtx_clk,
    input  tx_clk,
    input  rx_clk,
    input  rxd,
    input  rx_dv,
    input  rx_er
  );
endinterface : link_if

// file: hw/phy_end.sv
// Purpose: phy end of the link plus the receive buffer in front of it
// Assumes: link pins are sampled through two flip-flops on clk
// Notes:   data and its clock edge change in the same cycle at the sender
//
// Contract
// - mac sends mii nibbles on txd[3:0]
// - mac sends rgmii nibbles on txd[3:0]
// - mac sends gmii bytes on txd[7:0]
// - tx data follows the active tx clock
// - tx enable high marks valid tx data
// - rgmii tx control carries enable and error
// - mac sources free 125 MHz gig clock
// - mii tx error: invalid then halt symbols
// - gmii tx error: emit invalid code group
// - rgmii ignores the separate tx error pin
// - rx clock 2.5, 25 or 125 MHz
// - rgmii leaves the rx clock pin unused
// - rx nibbles in mii, bytes in gmii
// - rgmii rx data on rxd[3:0]
// - rx error high on detected errors
// - rgmii rx control carries valid and error
// - rx valid high while rx data valid
// - rgmii rx valid pin becomes rx clock
// - phy drives continuous mii tx clock
`timescale 1ns/1ps

// ****************************************
// stream fifo
// ****************************************
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // depth must be a power of two: the extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  // status and read port
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && !full)
        wr_ptr <= wr_ptr + (AW+1)'(1);
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
endmodule : stream_fifo

// ****************************************
// phy end
// ****************************************
module phy_end (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire link_pkg::speed_type speed,
  input  wire logic                rgmii_sel,
  link_if.phy                      link,
  output logic                     media_tx_valid,
  output logic [7:0]               media_tx_data,
  output link_pkg::kind_type       media_tx_kind,
  input  wire logic                media_rx_valid,
  input  wire logic [7:0]          media_rx_data,
  input  wire logic                media_rx_err,
  output logic                     media_rx_ready
);
  import link_pkg::*;

  mode_type                      mode;
  logic     [DIV_W-1:0]          div_count;
  logic                          div_level;
  logic                          div_wrap;
  logic                          div_rise;
  logic                          div_fall;
  logic     [10:0]               tx_meta;
  logic     [10:0]               tx_sync;
  logic                          gtx_prev;
  logic                          gtx_rise;
  logic                          gtx_fall;
  logic     [7:0]                t_d;
  logic                          t_en;
  logic                          t_er;
  logic     [3:0]                low_nib;
  logic                          low_err;
  logic                          tx_phase;
  logic                          err_run;
  logic                          rg_en;
  logic                          mii_err;
  logic                          fifo_valid;
  logic                          fifo_ready;
  logic     [FIFO_WIDTH-1:0]     fifo_data;
  logic     [FIFO_WIDTH-1:0]     rx_hold;
  logic                          rx_phase;
  logic                          rg_dv;
  logic     [7:0]                rxd_reg;
  logic                          rx_dv_reg;
  logic                          rx_er_reg;

  assign mode = pick_mode(speed, rgmii_sel);

  // ****************************************
  // local link clock
  // ****************************************
  // one divider serves mii tx clock and every rx clock
  assign div_wrap = (div_count >= half_count(speed) - 8'h01);
  assign div_rise = div_wrap && !div_level;
  assign div_fall = div_wrap && div_level;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_count <= DIV_RESET;
      div_level <= 1'b0;
    end
    else if (div_wrap)
    begin
      div_count <= DIV_RESET;
      div_level <= !div_level;
    end
    else
      div_count <= div_count + 8'h01;
  end

  // mii tx clock runs without pause; gig modes take the mac clock
  assign link.tx_clk = (mode == MODE_MII) ? div_level : 1'b0;
  assign link.rx_clk = (mode == MODE_RGMII) ? 1'b0 : div_level;
  assign link.rx_dv  = (mode == MODE_RGMII) ? div_level : rx_dv_reg;
  assign link.rx_er  = rx_er_reg;
  assign link.rxd    = rxd_reg;

  // ****************************************
  // transmit pins in
  // ****************************************
  // two flip-flops per pin, the first read by nothing else
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_meta  <= '0;
      tx_sync  <= '0;
      gtx_prev <= 1'b0;
    end
    else
    begin
      tx_meta  <= {link.gtx_clk, link.tx_er, link.tx_en, link.txd};
      tx_sync  <= tx_meta;
      gtx_prev <= tx_sync[10];
    end
  end

  assign t_d      = tx_sync[7:0];
  assign t_en     = tx_sync[8];
  assign t_er     = tx_sync[9];
  assign gtx_rise = tx_sync[10] && !gtx_prev;
  assign gtx_fall = !tx_sync[10] && gtx_prev;
  assign mii_err  = low_err || t_er;

  // ****************************************
  // transmit assembly
  // ****************************************
  // mii samples one period after its own edge so the mac has settled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      media_tx_valid <= 1'b0;
      media_tx_data  <= BYTE_RESET;
      media_tx_kind  <= KIND_DATA;
      low_nib        <= NIBBLE_RESET;
      low_err        <= 1'b0;
      tx_phase       <= 1'b0;
      err_run        <= 1'b0;
      rg_en          <= 1'b0;
    end
    else
    begin
      media_tx_valid <= 1'b0;
      case (mode)
        MODE_MII:
          if (div_rise)
          begin
            if (!t_en)
            begin
              tx_phase <= 1'b0;
              err_run  <= 1'b0;
            end
            else if (!tx_phase)
            begin
              low_nib  <= t_d[3:0];
              low_err  <= t_er;
              tx_phase <= 1'b1;
            end
            else
            begin
              media_tx_valid <= 1'b1;
              media_tx_data  <= {t_d[3:0], low_nib};
              // first errored byte is invalid, the rest halt
              media_tx_kind  <= !mii_err ? KIND_DATA
                              : (err_run ? KIND_HALT : KIND_INVALID);
              err_run        <= mii_err;
              tx_phase       <= 1'b0;
            end
          end
        MODE_GMII:
          if (gtx_rise && t_en)
          begin
            media_tx_valid <= 1'b1;
            media_tx_data  <= t_d;
            media_tx_kind  <= t_er ? KIND_INVALID : KIND_DATA;
          end
        MODE_RGMII:
          if (gtx_rise)
          begin
            low_nib <= t_d[3:0];
            rg_en   <= t_en;
          end
          else if (gtx_fall && rg_en)
          begin
            media_tx_valid <= 1'b1;
            media_tx_data  <= {t_d[3:0], low_nib};
            // error is control xor enable; the tx_er pin is not looked at
            media_tx_kind  <= (rg_en ^ t_en) ? KIND_INVALID : KIND_DATA;
          end
        default:
          media_tx_valid <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // receive buffer
  // ****************************************
  // media bytes wait here until the link has a slot for them
  stream_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) i_stream_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (media_rx_valid),
    .in_ready  (media_rx_ready),
    .in_data   ({media_rx_err, media_rx_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  assign fifo_ready = fifo_valid && div_rise && ((mode != MODE_MII) || !rx_phase);

  // ****************************************
  // receive drive
  // ****************************************
  // data changes in the same cycle as the clock edge it belongs to
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxd_reg   <= BYTE_RESET;
      rx_dv_reg <= 1'b0;
      rx_er_reg <= 1'b0;
      rx_hold   <= '0;
      rx_phase  <= 1'b0;
      rg_dv     <= 1'b0;
    end
    else
    begin
      case (mode)
        MODE_MII:
          if (div_rise && !rx_phase)
          begin
            rxd_reg   <= fifo_valid ? {4'h0, fifo_data[3:0]} : BYTE_RESET;
            rx_dv_reg <= fifo_valid;
            rx_er_reg <= fifo_valid && fifo_data[8];
            rx_hold   <= fifo_data;
            rx_phase  <= fifo_valid;
          end
          else if (div_rise)
          begin
            rxd_reg  <= {4'h0, rx_hold[7:4]};
            rx_phase <= 1'b0;
          end
        MODE_GMII:
          if (div_rise)
          begin
            rxd_reg   <= fifo_valid ? fifo_data[7:0] : BYTE_RESET;
            rx_dv_reg <= fifo_valid;
            rx_er_reg <= fifo_valid && fifo_data[8];
          end
        MODE_RGMII:
          if (div_rise)
          begin
            rxd_reg   <= fifo_valid ? {4'h0, fifo_data[3:0]} : BYTE_RESET;
            rx_er_reg <= fifo_valid;
            rx_hold   <= fifo_data;
            rg_dv     <= fifo_valid;
            rx_dv_reg <= 1'b0;
            rx_phase  <= 1'b0;
          end
          else if (div_fall)
          begin
            rxd_reg   <= rg_dv ? {4'h0, rx_hold[7:4]} : BYTE_RESET;
            rx_er_reg <= rg_dv && !rx_hold[8];
          end
        default:
          rx_phase <= 1'b0;
      endcase
    end
  end
endmodule : phy_end

// file: hw/mac_end.sv
// Purpose: mac end of the link, byte streams on the user side
// Assumes: link pins are sampled through two flip-flops on clk
// Notes:   a byte is taken only in its link slot; tx_ready marks the slot
`timescale 1ns/1ps
module mac_end (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire link_pkg::speed_type speed,
  input  wire logic                rgmii_sel,
  link_if.mac                      link,
  input  wire logic                tx_valid,
  input  wire logic [7:0]          tx_data,
  input  wire logic                tx_err,
  output logic                     tx_ready,
  output logic                     rx_valid,
  output logic [7:0]               rx_data,
  output logic                     rx_err
);
  import link_pkg::*;

  mode_type             mode;
  logic     [DIV_W-1:0] div_count;
  logic                 div_level;
  logic                 div_wrap;
  logic     [11:0]      rx_meta;
  logic     [11:0]      rx_sync;
  logic                 rxc;
  logic                 rxc_prev;
  logic                 tck_prev;
  logic                 mii_tx_rise;
  logic                 r_rise;
  logic                 r_fall;
  logic     [7:0]       txd_reg;
  logic                 tx_en_reg;
  logic     [3:0]       tx_high;
  logic                 tx_hold_en;
  logic                 tx_hold_err;
  logic                 tx_phase;
  logic     [3:0]       rx_low;
  logic                 rx_low_err;
  logic                 rx_phase;

  assign mode = pick_mode(speed, rgmii_sel);

  // ****************************************
  // gig transmit clock
  // ****************************************
  // runs free so the phy always sees a clock in gig modes
  assign div_wrap = (div_count >= half_count(speed) - 8'h01);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_count <= DIV_RESET;
      div_level <= 1'b0;
    end
    else if (div_wrap)
    begin
      div_count <= DIV_RESET;
      div_level <= !div_level;
    end
    else
      div_count <= div_count + 8'h01;
  end

  assign link.gtx_clk = (mode == MODE_MII) ? 1'b0 : div_level;
  assign link.txd     = txd_reg;
  assign link.tx_en   = tx_en_reg;

  // ****************************************
  // receive pins in
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_meta  <= '0;
      rx_sync  <= '0;
      rxc_prev <= 1'b0;
      tck_prev <= 1'b0;
    end
    else
    begin
      rx_meta  <= {link.tx_clk, link.rx_clk, link.rx_er, link.rx_dv, link.rxd};
      rx_sync  <= rx_meta;
      rxc_prev <= rxc;
      tck_prev <= rx_sync[11];
    end
  end

  // rgmii clock arrives on the valid pin
  assign rxc         = (mode == MODE_RGMII) ? rx_sync[8] : rx_sync[10];
  assign r_rise      = rxc && !rxc_prev;
  assign r_fall      = !rxc && rxc_prev;
  assign mii_tx_rise = rx_sync[11] && !tck_prev;

  // slot in which a user byte is taken
  assign tx_ready = (mode == MODE_MII) ? (mii_tx_rise && !tx_phase)
                                       : (div_wrap && !div_level);

  // ****************************************
  // transmit drive
  // ****************************************
  // tx_er stays low in rgmii; the phy would ignore it anyway
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txd_reg     <= BYTE_RESET;
      tx_en_reg   <= 1'b0;
      link.tx_er  <= 1'b0;
      tx_high     <= NIBBLE_RESET;
      tx_hold_en  <= 1'b0;
      tx_hold_err <= 1'b0;
      tx_phase    <= 1'b0;
    end
    else
    begin
      case (mode)
        MODE_MII:
          if (tx_ready)
          begin
            txd_reg     <= tx_valid ? {4'h0, tx_data[3:0]} : BYTE_RESET;
            tx_en_reg   <= tx_valid;
            link.tx_er  <= tx_valid && tx_err;
            tx_high     <= tx_data[7:4];
            tx_phase    <= tx_valid;
          end
          else if (mii_tx_rise)
          begin
            txd_reg  <= {4'h0, tx_high};
            tx_phase <= 1'b0;
          end
        MODE_GMII:
          if (tx_ready)
          begin
            txd_reg    <= tx_valid ? tx_data : BYTE_RESET;
            tx_en_reg  <= tx_valid;
            link.tx_er <= tx_valid && tx_err;
            tx_phase   <= 1'b0;
          end
        MODE_RGMII:
          if (tx_ready)
          begin
            txd_reg     <= tx_valid ? {4'h0, tx_data[3:0]} : BYTE_RESET;
            tx_en_reg   <= tx_valid;
            link.tx_er  <= 1'b0;
            tx_high     <= tx_data[7:4];
            tx_hold_en  <= tx_valid;
            tx_hold_err <= tx_err;
            tx_phase    <= 1'b0;
          end
          else if (div_wrap)
          begin
            txd_reg   <= tx_hold_en ? {4'h0, tx_high} : BYTE_RESET;
            tx_en_reg <= tx_hold_en && !tx_hold_err;
          end
        default:
          tx_phase <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // receive assembly
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_valid   <= 1'b0;
      rx_data    <= BYTE_RESET;
      rx_err     <= 1'b0;
      rx_low     <= NIBBLE_RESET;
      rx_low_err <= 1'b0;
      rx_phase   <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      case (mode)
        MODE_MII:
          if (r_rise && !rx_sync[8])
            rx_phase <= 1'b0;
          else if (r_rise && !rx_phase)
          begin
            rx_low     <= rx_sync[3:0];
            rx_low_err <= rx_sync[9];
            rx_phase   <= 1'b1;
          end
          else if (r_rise)
          begin
            rx_valid <= 1'b1;
            rx_data  <= {rx_sync[3:0], rx_low};
            rx_err   <= rx_low_err || rx_sync[9];
            rx_phase <= 1'b0;
          end
        MODE_GMII:
          if (r_rise && rx_sync[8])
          begin
            rx_valid <= 1'b1;
            rx_data  <= rx_sync[7:0];
            rx_err   <= rx_sync[9];
          end
        MODE_RGMII:
          if (r_rise)
          begin
            rx_low   <= rx_sync[3:0];
            rx_phase <= rx_sync[9];
          end
          else if (r_fall && rx_phase)
          begin
            rx_valid <= 1'b1;
            rx_data  <= {rx_sync[3:0], rx_low};
            rx_err   <= !rx_sync[9];
          end
        default:
          rx_valid <= 1'b0;
      endcase
    end
  end
endmodule : mac_end

// file: verif/link_asserts.sv
// Purpose: assertions on the pins between the two ends
// Assumes: speed and rgmii_sel change only while reset is held
// Notes:   watches the first link only
`timescale 1ns/1ps
module link_asserts (
  input logic                clk,
  input logic                rst,
  input link_pkg::speed_type speed,
  input logic                rgmii_sel,
  input logic [7:0]          txd,
  input logic                tx_er,
  input logic                gtx_clk,
  input logic                tx_clk,
  input logic                rx_clk,
  input logic [7:0]          rxd,
  input logic                rx_dv
);
  import link_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // clocks and pins
  // ****************************************
  // error travels on the control pin in rgmii
  tx_er_quiet_a: assert property (rgmii_sel |-> !tx_er)
    else $error("tx error pin driven in rgmii");
  rx_clk_idle_a: assert property (rgmii_sel |-> !rx_clk)
    else $error("rx clock pin used in rgmii");
  gtx_idle_a: assert property (!rgmii_sel && speed != SPEED_1000 |-> !gtx_clk)
    else $error("gig clock runs in mii");
  gtx_rate_a: assert property (speed == SPEED_1000 && $rose(gtx_clk)
    |=> !gtx_clk ##1 gtx_clk) else $error("gig clock off rate");
  rx_clk_rate_a: assert property (!rgmii_sel && speed == SPEED_100 && $rose(rx_clk)
    |-> rx_clk[*5] ##1 !rx_clk[*5] ##1 rx_clk) else $error("rx clock off rate");
  tx_clk_rate_a: assert property (!rgmii_sel && speed == SPEED_10 && $rose(tx_clk)
    |-> ##100 $rose(tx_clk)) else $error("tx clock off rate");
  // data must move only with its clock edge
  rxd_sync_a: assert property (!rgmii_sel && $changed(rxd) |-> $rose(rx_clk))
    else $error("rx data off its clock");
  txd_sync_a: assert property (!rgmii_sel && speed == SPEED_1000 && $changed(txd)
    |-> $rose(gtx_clk)) else $error("tx data off its clock");
  rgmii_clk_run_a: assert property (rgmii_sel && speed == SPEED_1000 && $rose(rx_dv)
    |=> !rx_dv ##1 rx_dv) else $error("rgmii rx clock off rate");
endmodule : link_asserts

// file: verif/phy_mac_side_data_interface_test.sv
// Purpose: drives both ends in every mode and compares the streams
// Assumes: mode changes only while reset is held
// Notes:   faults of the far side are not injected; one link only
`timescale 1ns/1ps
module phy_mac_side_data_interface_test;
  import link_pkg::*;
  localparam int LIMIT = 8000; // fill scenario dominates, about 3.2k cycles
  logic        clk, rst, rgmii_sel, tx_valid, tx_err, tx_ready, rx_valid, rx_err;
  logic        media_tx_valid, media_rx_valid, media_rx_err, media_rx_ready;
  logic [7:0]  tx_data, rx_data, media_tx_data, media_rx_data;
  speed_type   speed;
  kind_type    media_tx_kind;
  logic [15:0] exp_tx[$], got_tx[$], exp_rx[$], got_rx[$];
  int          n_errors, n_checks, cycles;
  link_if lnk();
  phy_end i_phy_end (.clk(clk), .rst(rst), .speed(speed), .rgmii_sel(rgmii_sel), .link(lnk),
    .media_tx_valid(media_tx_valid), .media_tx_data(media_tx_data),
    .media_tx_kind(media_tx_kind), .media_rx_valid(media_rx_valid),
    .media_rx_data(media_rx_data), .media_rx_err(media_rx_err), .media_rx_ready(media_rx_ready));
  mac_end i_mac_end (.clk(clk), .rst(rst), .speed(speed), .rgmii_sel(rgmii_sel), .link(lnk),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_err(tx_err), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err));
  link_asserts i_link_asserts (.clk(clk), .rst(rst), .speed(speed), .rgmii_sel(rgmii_sel),
    .txd(lnk.txd), .tx_er(lnk.tx_er), .gtx_clk(lnk.gtx_clk), .tx_clk(lnk.tx_clk),
    .rx_clk(lnk.rx_clk), .rxd(lnk.rxd), .rx_dv(lnk.rx_dv));
  // ****************************************
  // clock, watchdog, collection
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // sampled mid-cycle so pulses are settled
  always @(negedge clk)
  begin
    if (media_tx_valid === 1'b1) got_tx.push_back(16'({media_tx_kind, media_tx_data}));
    if (rx_valid === 1'b1) got_rx.push_back(16'({rx_err, rx_data}));
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task print_verdict();
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task set_mode(input speed_type s, input logic r);
    rst = 1'b1;
    speed = s;
    rgmii_sel = r;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
  endtask : set_mode
  // held until the slot takes it; valid stays up for back to back bytes
  task send_tx(input logic [7:0] d, input logic e, input kind_type k);
    tx_data = d;
    tx_err = e;
    tx_valid = 1'b1;
    do @(negedge clk); while (tx_ready !== 1'b1);
    @(posedge clk);
    #1 exp_tx.push_back(16'({k, d}));
  endtask : send_tx
  task send_rx(input logic [7:0] d, input logic e);
    media_rx_data = d;
    media_rx_err = e;
    media_rx_valid = 1'b1;
    do @(negedge clk); while (media_rx_ready !== 1'b1);
    @(posedge clk);
    #1 media_rx_valid = 1'b0;
    exp_rx.push_back(16'({e, d}));
    @(posedge clk);
    #1;
  endtask : send_rx
  task drain(input int wait_max);
    int i;
    tx_valid = 1'b0;
    i = 0;
    while (i < wait_max && (got_tx.size() < exp_tx.size() || got_rx.size() < exp_rx.size()))
    begin
      @(posedge clk);
      i++;
    end
    check(16'(got_tx.size()), 16'(exp_tx.size()));
    check(16'(got_rx.size()), 16'(exp_rx.size()));
    while (got_tx.size() > 0 && exp_tx.size() > 0)
      check(got_tx.pop_front(), exp_tx.pop_front());
    while (got_rx.size() > 0 && exp_rx.size() > 0)
      check(got_rx.pop_front(), exp_rx.pop_front());
    got_tx.delete();
    got_rx.delete();
    exp_tx.delete();
    exp_rx.delete();
  endtask : drain
  // ****************************************
  // scenarios
  // ****************************************
  task t_gmii();
    set_mode(SPEED_1000, 1'b0);
    send_rx(8'h81, 1'b0);
    send_rx(8'h7e, 1'b1);
    send_tx(8'h00, 1'b0, KIND_DATA);
    send_tx(8'ha5, 1'b1, KIND_INVALID);
    send_tx(8'hff, 1'b0, KIND_DATA);
    drain(400);
  endtask : t_gmii
  task t_rgmii();
    set_mode(SPEED_1000, 1'b1);
    send_rx(8'h5a, 1'b0);
    send_rx(8'hc3, 1'b1);
    send_tx(8'h96, 1'b0, KIND_DATA);
    send_tx(8'h0f, 1'b0, KIND_DATA);
    send_tx(8'h3c, 1'b1, KIND_INVALID);
    drain(400);
  endtask : t_rgmii
  // error run: invalid first, halt while it lasts
  task t_mii();
    set_mode(SPEED_100, 1'b0);
    send_rx(8'he1, 1'b1);
    send_rx(8'h2d, 1'b0);
    send_tx(8'h12, 1'b0, KIND_DATA);
    send_tx(8'h34, 1'b1, KIND_INVALID);
    send_tx(8'h56, 1'b1, KIND_HALT);
    send_tx(8'h78, 1'b1, KIND_HALT);
    send_tx(8'h9a, 1'b0, KIND_DATA);
    send_tx(8'hbc, 1'b1, KIND_INVALID);
    drain(800);
  endtask : t_mii
  // slow link lets the buffer fill until it refuses
  task t_fill();
    int i;
    logic full;
    set_mode(SPEED_10, 1'b0);
    full = 1'b0;
    media_rx_err = 1'b0;
    media_rx_valid = 1'b1;
    for (i = 0; i < 24 && !full; i++)
    begin
      media_rx_data = 8'(i);
      @(negedge clk);
      full = !media_rx_ready;
      @(posedge clk);
      #1 if (!full) exp_rx.push_back(16'(i));
    end
    media_rx_valid = 1'b0;
    check(16'({full, exp_rx.size() > 15}), 16'h0003);
    drain(5000);
  endtask : t_fill
  initial
  begin
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_err = 1'b0;
    media_rx_valid = 1'b0;
    media_rx_data = 8'h00;
    media_rx_err = 1'b0;
    t_gmii();
    t_rgmii();
    t_mii();
    t_fill();
    print_verdict();
  end
endmodule : phy_mac_side_data_interface_test
